// [dv/fawp_array_model.sv]
`timescale 1ns/100ps
module fawp_array_model
    import fawp_pkg::*;
(
    input  wire logic                        ref_clk,     // Device clock
    input  wire logic                        sys_rst,     // Sync reset, active high
    input  wire logic                        array_req,   // Granted op pulse
    input  wire logic                        array_erase, // Erase, else program
    input  wire logic                        array_blk,   // Block wide erase
    input  wire logic [fawp_pkg::ADDR_W-1:0] array_addr,  // Op address
    output logic      [15:0]                 op_count,    // Ops reached the array
    output logic      [26:0]                 last_op      // Erase, block, address
);
    import fawp_pkg::*;

    logic [15:0] op_count_d;
    logic [26:0] last_op_d;

    // Only granted operations reach the cells; a refused one leaves no trace here
    always_comb
    begin
        op_count_d = op_count;
        last_op_d  = last_op;
        if (array_req)
        begin
            op_count_d = op_count + 16'h0001;
            last_op_d  = {array_erase, array_blk, array_addr};
        end
    end

    // Counter survives everything but the device reset
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            op_count <= 16'h0000;
            last_op  <= 27'h0000000;
        end
        else
        begin
            op_count <= op_count_d;
            last_op  <= last_op_d;
        end
    end
endmodule

// [dv/tb_flash_array_write_protect.sv]
`timescale 1ns/100ps
module tb_flash_array_write_protect;
    import fawp_pkg::*;
    logic        ref_clk;
    logic        sys_rst;
    logic        hw_rst_n_pin;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        array_req;
    logic        array_erase;
    logic        array_blk;
    logic [24:0] array_addr;
    logic [15:0] op_count;
    logic [26:0] last_op;
    logic [31:0] rd;
    logic        err_q;
    int          failures;
    int          cmp_count;

    fawp_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hw_rst_n_pin(hw_rst_n_pin),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .array_req(array_req),
        .array_erase(array_erase), .array_blk(array_blk), .array_addr(array_addr));

    fawp_array_model u_array (.ref_clk(ref_clk), .sys_rst(sys_rst), .array_req(array_req),
        .array_erase(array_erase), .array_blk(array_blk), .array_addr(array_addr),
        .op_count(op_count), .last_op(last_op));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; entered right after a rising edge, leaves one idle edge behind
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            $display("[FAIL] %0t: bus answer missing", $time);
            wrap_up();
        end
        rd      = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Issue a command and poll status until the engine is idle again
    task automatic do_cmd(input logic [3:0] code, input logic [24:0] addr);
        int n;
        apb(1'b1, REG_ADDR, 32'(addr));
        apb(1'b1, REG_CMD, 32'(code));
        for (n = 0; n < 20; n++)
        begin
            apb(1'b0, REG_STAT, 32'h0);
            if (rd[STAT_BUSY] === 1'b0)
                break;
        end
        if (n == 20)
        begin
            failures++;
            $display("[FAIL] %0t: command never finished", $time);
            wrap_up();
        end
    endtask

    task automatic op_chk(input logic [3:0] code, input logic [24:0] addr, input logic refd);
        logic [15:0] n0;
        n0 = op_count;
        do_cmd(code, addr);
        chk(32'(rd[STAT_REFUSED]), 32'(refd));
        chk(32'(rd[STAT_DONE]), 32'h1);
        chk(32'(op_count - n0), refd ? 32'h0 : 32'h1);
        if (!refd)
            chk(32'(last_op[24:0]), 32'(addr));
    endtask

    task automatic bit_chk(input logic [24:0] addr, input logic exp);
        do_cmd(CMD_READ, addr);
        chk(32'(rd[STAT_RDBIT]), 32'(exp));
    endtask

    task automatic sc_reset_values();
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h00000080);
        apb(1'b0, REG_STAT, 32'h0);
        chk(rd, 32'h00000000);
        chk(32'(err_q), 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk(32'(err_q), 32'h1);
    endtask

    // Every level and both ends, probing both array ends and the half boundary
    task automatic sc_legacy();
        int   blks[4] = '{0, 255, 256, 511};
        int   cnt;
        logic exp_p;
        for (int lv = 0; lv < 16; lv++)
            for (int tb = 0; tb < 2; tb++)
            begin
                cnt = (lv == 0) ? 0 : (lv >= 10) ? 512 : (1 << (lv - 1));
                apb(1'b1, REG_CTRL, 32'(lv) | (32'(tb) << CTRL_TB) | 32'h80);
                foreach (blks[i])
                begin
                    exp_p = (tb == 1) ? (blks[i] < cnt) : (blks[i] >= 512 - cnt);
                    op_chk(CMD_PROG, 25'(blks[i]) << 16, exp_p);
                end
            end
    endtask

    task automatic sc_pointer();
        apb(1'b1, REG_PTR, 32'h5);
        apb(1'b1, REG_CTRL, 32'h180);
        op_chk(CMD_PROG, 25'h0005000, 1'b0);
        op_chk(CMD_PROG, 25'h0006000, 1'b1);
        apb(1'b1, REG_CTRL, 32'h380);
        op_chk(CMD_PROG, 25'h0004000, 1'b1);
        apb(1'b1, REG_CTRL, 32'h580);
        op_chk(CMD_PROG, 25'h0005000, 1'b1);
        apb(1'b1, REG_CTRL, 32'h1c0);
        do_cmd(CMD_GUNLOCK, 25'h0);
        op_chk(CMD_PROG, 25'h0006000, 1'b1);
        op_chk(CMD_PROG, 25'h0005000, 1'b0);
    endtask

    task automatic sc_locks();
        apb(1'b1, REG_CTRL, 32'h0c0);
        do_cmd(CMD_GLOCK, 25'h0);
        bit_chk(25'h0050000, 1'b0);
        op_chk(CMD_PROG, 25'h0050000, 1'b1);
        do_cmd(CMD_GUNLOCK, 25'h0);
        bit_chk(25'h1fff000, 1'b1);
        op_chk(CMD_PROG, 25'h0050000, 1'b0);
        do_cmd(CMD_LOCK, 25'h0001000);
        bit_chk(25'h0001000, 1'b0);
        bit_chk(25'h0000000, 1'b1);
        op_chk(CMD_ERASE_BLK, 25'h0, 1'b1);
        bit_chk(25'h0000000, 1'b1);
        op_chk(CMD_ERASE_SEC, 25'h0, 1'b0);
        chk(32'(last_op[26:25]), 32'h2);
        op_chk(CMD_PROG, 25'h0001800, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            do_cmd(CMD_UNLOCK, 25'h0001000);
            do_cmd(CMD_LOCK, 25'h0001000);
        end
        do_cmd(CMD_UNLOCK, 25'h0001000);
        bit_chk(25'h0001000, 1'b1);
        op_chk(CMD_ERASE_BLK, 25'h0, 1'b0);
        chk(32'(last_op[26:25]), 32'h3);
    endtask

    task automatic sc_resets();
        apb(1'b1, REG_CTRL, 32'h040);
        do_cmd(CMD_GLOCK, 25'h0);
        hw_rst_n_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        hw_rst_n_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        bit_chk(25'h0050000, 1'b1);
        apb(1'b1, REG_CTRL, 32'h0c0);
        do_cmd(CMD_SWRESET, 25'h0);
        bit_chk(25'h0050000, 1'b0);
        do_cmd(CMD_GUNLOCK, 25'h0);
        hw_rst_n_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        hw_rst_n_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        bit_chk(25'h1fff000, 1'b0);
    endtask

    initial
    begin
        failures     = 0;
        cmp_count    = 0;
        sys_rst      = 1'b1;
        hw_rst_n_pin = 1'b1;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 8'h00;
        pwdata       = 32'h00000000;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        sc_reset_values();
        bit_chk(25'h0050000, 1'b0);
        sc_legacy();
        sc_pointer();
        sc_locks();
        sc_resets();
        wrap_up();
    end
endmodule

// [rtl/fawp_legacy_range.sv]
`timescale 1ns/100ps
module fawp_legacy_range
    import fawp_pkg::*;
(
    input  wire logic [3:0] protect_level,     // Protect level code
    input  wire logic       top_bottom_select, // 0 top, 1 bottom
    input  wire logic [8:0] block,             // Block under test
    output logic            hit                // Block is protected
);
    import fawp_pkg::*;

    logic [9:0] count;

    // Count is zero at code 0, else a power of two; codes from LVL_ALL up cover the array
    always_comb
    begin
        if (protect_level == 4'h0)
            count = 10'h000;
        else if (protect_level >= LVL_ALL)
            count = BLK_CNT_V;
        else
            count = 10'h001 << (protect_level - 4'h1);
    end

    // Top grows down from the last block, bottom grows up from block zero
    always_comb
    begin
        if (top_bottom_select)
            hit = ({1'b0, block} < count);
        else
            hit = ({1'b0, block} >= (BLK_CNT_V - count));
    end
endmodule

// [rtl/fawp_pkg.sv]
package fawp_pkg;
    // Array geometry
    localparam int unsigned BLK_CNT       = 512;
    localparam int unsigned SEC_PER_BLK   = 16;
    localparam int unsigned UNIT_CNT      = 542;
    localparam int unsigned ADDR_W        = 25;
    localparam int unsigned SEC_W         = 13;
    localparam int unsigned BLK_W         = 9;
    localparam int unsigned UNIT_W        = 10;
    localparam int unsigned LVL_W         = 4;
    localparam logic [9:0]  BLK_CNT_V     = 10'h200;
    localparam logic [8:0]  TOP_BLK       = 9'h1ff;
    localparam logic [9:0]  MID_UNIT_OFS  = 10'h00f;
    localparam logic [9:0]  TOP_UNIT_BASE = 10'h20e;
    localparam logic [3:0]  LVL_ALL       = 4'ha;
    localparam int unsigned SYNC_STAGES   = 2;

    // Register byte offsets
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_PTR       = 8'h04;
    localparam logic [7:0]  REG_ADDR      = 8'h08;
    localparam logic [7:0]  REG_CMD       = 8'h0c;
    localparam logic [7:0]  REG_STAT      = 8'h10;

    // Control field positions and reset value
    localparam int unsigned CTRL_LVL      = 0;
    localparam int unsigned CTRL_TB       = 4;
    localparam int unsigned CTRL_CMP      = 5;
    localparam int unsigned CTRL_WPS      = 6;
    localparam int unsigned CTRL_LDS      = 7;
    localparam int unsigned CTRL_PRG      = 8;
    localparam int unsigned CTRL_PDIR     = 9;
    localparam int unsigned CTRL_PALL     = 10;
    localparam int unsigned CTRL_W        = 11;
    localparam logic [10:0] CTRL_RST      = 11'h080;
    localparam logic [12:0] PTR_RST       = 13'h0000;
    localparam logic [24:0] ADDR_RST      = 25'h0000000;

    // Status field positions
    localparam int unsigned STAT_BUSY     = 0;
    localparam int unsigned STAT_RDBIT    = 1;
    localparam int unsigned STAT_REFUSED  = 2;
    localparam int unsigned STAT_DONE     = 3;

    // Command codes written to the command register
    localparam logic [3:0]  CMD_NONE      = 4'h0;
    localparam logic [3:0]  CMD_LOCK      = 4'h1;
    localparam logic [3:0]  CMD_UNLOCK    = 4'h2;
    localparam logic [3:0]  CMD_GLOCK     = 4'h3;
    localparam logic [3:0]  CMD_GUNLOCK   = 4'h4;
    localparam logic [3:0]  CMD_READ      = 4'h5;
    localparam logic [3:0]  CMD_PROG      = 4'h6;
    localparam logic [3:0]  CMD_ERASE_SEC = 4'h7;
    localparam logic [3:0]  CMD_ERASE_BLK = 4'h8;
    localparam logic [3:0]  CMD_SWRESET   = 4'h9;

    typedef enum logic {
        st_idle,
        st_run
    } fawp_state_t;
endpackage

// [rtl/fawp_top.sv]
`timescale 1ns/100ps
module fawp_top
    import fawp_pkg::*;
(
    input  wire logic                 ref_clk,      // Device clock, 25 MHz
    input  wire logic                 sys_rst,      // Sync reset, active high
    input  wire logic                 hw_rst_n_pin, // Hardware reset pin, low
    input  wire logic                 psel,         // APB select
    input  wire logic                 penable,      // APB enable
    input  wire logic                 pwrite,       // APB direction
    input  wire logic [7:0]           paddr,        // APB byte address
    input  wire logic [31:0]          pwdata,       // APB write data
    output logic [31:0]               prdata,       // APB read data
    output logic                      pready,       // APB ready
    output logic                      pslverr,      // APB error, unmapped
    output logic                      array_req,    // Granted array op pulse
    output logic                      array_erase,  // Op is an erase
    output logic                      array_blk,    // Erase is block wide
    output logic [fawp_pkg::ADDR_W-1:0] array_addr  // Op address
);
    import fawp_pkg::*;

    // Register state
    logic [CTRL_W-1:0]   ctrl_q,  ctrl_d;
    logic [SEC_W-1:0]    ptr_q,   ptr_d;
    logic [ADDR_W-1:0]   addr_q,  addr_d;
    logic [3:0]          cmd_q,   cmd_d;
    fawp_state_t         state_q, state_d;
    logic [UNIT_CNT-1:0] lock_q,  lock_d;
    logic                rd_bit_q, rd_bit_d;
    logic                refused_q, refused_d;
    logic                done_q,  done_d;
    logic                req_q,   req_d;
    logic                erase_q, erase_d;
    logic                blkop_q, blkop_d;
    logic [ADDR_W-1:0]   aaddr_q, aaddr_d;
    logic [31:0]         rdata_q, rdata_d;
    logic                sync1_q, sync2_q;

    // Decode signals
    logic                wr_acc;
    logic                setup_rd;
    logic                mapped;
    logic [31:0]         rd_mux;
    logic [BLK_W-1:0]    blk;
    logic [3:0]          sec;
    logic [UNIT_W-1:0]   unit;
    logic                cur_bit;
    logic                edge_ok;
    logic                lock_hit;
    logic                legacy_hit;
    logic                scheme_hit;
    logic                ptr_hit;
    logic                prot;
    logic                arr_cmd;
    logic                hw_hold;
    logic [SEC_W-1:0]    sec_lo, sec_hi;
    logic [UNIT_CNT-1:0] lock_dflt;

    // Map an address to its lock unit: sectors in edge blocks, else blocks
    function automatic logic [UNIT_W-1:0] unit_of(input logic [ADDR_W-1:0] a);
        logic [BLK_W-1:0] b;
        logic [3:0]       s;
        b = a[24:16];
        s = a[15:12];
        if (b == 9'h000)
            unit_of = {6'h00, s};
        else if (b == TOP_BLK)
            unit_of = TOP_UNIT_BASE + {6'h00, s};
        else
            unit_of = {1'b0, b} + MID_UNIT_OFS;
    endfunction

    // Hardware reset pin crosses in through two flops before use
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end
        else
        begin
            sync1_q <= hw_rst_n_pin;
            sync2_q <= sync1_q;
        end
    end

    assign hw_hold = ~sync2_q;

    // Bus phase decode; zero wait states keep the slave trivially simple
    assign wr_acc   = psel & penable & pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign mapped   = (paddr == REG_CTRL) || (paddr == REG_PTR) || (paddr == REG_ADDR)
                   || (paddr == REG_CMD) || (paddr == REG_STAT);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign prdata   = rdata_q;

    // Read mux; command register reads back the last accepted code
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (paddr == REG_CTRL)
            rd_mux = {21'h000000, ctrl_q};
        else if (paddr == REG_PTR)
            rd_mux = {19'h00000, ptr_q};
        else if (paddr == REG_ADDR)
            rd_mux = {7'h00, addr_q};
        else if (paddr == REG_CMD)
            rd_mux = {28'h0000000, cmd_q};
        else if (paddr == REG_STAT)
            rd_mux = {28'h0000000, done_q, refused_q, rd_bit_q, (state_q == st_run)};
    end

    // Read data is captured in the setup cycle and stands for the access
    always_comb
    begin
        rdata_d = rdata_q;
        if (setup_rd)
            rdata_d = rd_mux;
    end

    // Configuration writes take effect at the access edge
    always_comb
    begin
        ctrl_d = ctrl_q;
        ptr_d  = ptr_q;
        addr_d = addr_q;
        if (wr_acc && paddr == REG_CTRL)
            ctrl_d = pwdata[CTRL_W-1:0];
        else if (wr_acc && paddr == REG_PTR)
            ptr_d = pwdata[SEC_W-1:0];
        else if (wr_acc && paddr == REG_ADDR && state_q == st_idle)
            addr_d = pwdata[ADDR_W-1:0];
    end

    // Protection decision for the address held in the address register
    assign blk     = addr_q[24:16];
    assign sec     = addr_q[15:12];
    assign unit    = unit_of(addr_q);
    assign cur_bit = lock_q[unit];
    assign arr_cmd = (cmd_q == CMD_PROG) || (cmd_q == CMD_ERASE_SEC)
                  || (cmd_q == CMD_ERASE_BLK);
    assign edge_ok = (blk == 9'h000) ? (&lock_q[15:0]) : (&lock_q[UNIT_CNT-1:UNIT_CNT-16]);

    // A block erase on an edge block needs all sixteen sector bits open
    always_comb
    begin
        if (cmd_q == CMD_ERASE_BLK && (blk == 9'h000 || blk == TOP_BLK))
            lock_hit = ~edge_ok;
        else
            lock_hit = ~cur_bit;
    end

    fawp_legacy_range u_legacy (
        .protect_level     (ctrl_q[CTRL_LVL +: LVL_W]),
        .top_bottom_select (ctrl_q[CTRL_TB]),
        .block             (blk),
        .hit               (legacy_hit)
    );

    // Complement mode is stored but not decoded; it reads back only
    assign scheme_hit = ctrl_q[CTRL_WPS] ? lock_hit : legacy_hit;

    // Pointer region: the pointed sector and one side stay open unless CTRL_PALL protects all
    assign sec_lo = (cmd_q == CMD_ERASE_BLK) ? {blk, 4'h0} : {blk, sec};
    assign sec_hi = (cmd_q == CMD_ERASE_BLK) ? {blk, 4'hf} : {blk, sec};
    always_comb
    begin
        if (!ctrl_q[CTRL_PRG])
            ptr_hit = 1'b0;
        else if (ctrl_q[CTRL_PALL])
            ptr_hit = 1'b1;
        else if (ctrl_q[CTRL_PDIR])
            ptr_hit = (sec_lo < ptr_q);
        else
            ptr_hit = (sec_hi > ptr_q);
    end

    assign prot = scheme_hit | ptr_hit;

    // Command sequencer: accept in idle, act for one cycle in run
    always_comb
    begin
        state_d   = state_q;
        cmd_d     = cmd_q;
        refused_d = refused_q;
        done_d    = done_q;
        rd_bit_d  = rd_bit_q;
        req_d     = 1'b0;
        erase_d   = erase_q;
        blkop_d   = blkop_q;
        aaddr_d   = aaddr_q;
        case (state_q)
            st_idle:
            begin
                // Writes while busy are dropped; status shows busy
                if (wr_acc && paddr == REG_CMD && pwdata[3:0] != CMD_NONE)
                begin
                    cmd_d     = pwdata[3:0];
                    state_d   = st_run;
                    refused_d = 1'b0;
                    done_d    = 1'b0;
                end
            end
            st_run:
            begin
                state_d = st_idle;
                done_d  = 1'b1;
                if (cmd_q == CMD_READ)
                    rd_bit_d = cur_bit;
                if (arr_cmd && prot)
                    refused_d = 1'b1;
                else if (arr_cmd)
                begin
                    req_d   = 1'b1;
                    erase_d = (cmd_q != CMD_PROG);
                    blkop_d = (cmd_q == CMD_ERASE_BLK);
                    aaddr_d = addr_q;
                end
            end
            default:
                state_d = st_idle;
        endcase
    end

    // Reset default for the lock bits follows the default select bit
    assign lock_dflt = ctrl_q[CTRL_LDS] ? {UNIT_CNT{1'b0}} : {UNIT_CNT{1'b1}};

    // Lock bits are plain flops, so any number of changes is fine
    always_comb
    begin
        lock_d = lock_q;
        if (hw_hold)
            lock_d = lock_dflt;
        else if (state_q == st_run)
        begin
            case (cmd_q)
                CMD_LOCK:    lock_d[unit] = 1'b0;
                CMD_UNLOCK:  lock_d[unit] = 1'b1;
                CMD_GLOCK:   lock_d = {UNIT_CNT{1'b0}};
                CMD_GUNLOCK: lock_d = {UNIT_CNT{1'b1}};
                CMD_SWRESET: lock_d = lock_dflt;
                default:     lock_d = lock_q;
            endcase
        end
    end

    // All state registers but the pin synchroniser; bits start protected as the select resets to one
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ctrl_q    <= CTRL_RST;
            ptr_q     <= PTR_RST;
            addr_q    <= ADDR_RST;
            cmd_q     <= CMD_NONE;
            state_q   <= st_idle;
            lock_q    <= {UNIT_CNT{1'b0}};
            rd_bit_q  <= 1'b0;
            refused_q <= 1'b0;
            done_q    <= 1'b0;
            req_q     <= 1'b0;
            erase_q   <= 1'b0;
            blkop_q   <= 1'b0;
            aaddr_q   <= ADDR_RST;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            ptr_q     <= ptr_d;
            addr_q    <= addr_d;
            cmd_q     <= cmd_d;
            state_q   <= state_d;
            lock_q    <= lock_d;
            rd_bit_q  <= rd_bit_d;
            refused_q <= refused_d;
            done_q    <= done_d;
            req_q     <= req_d;
            erase_q   <= erase_d;
            blkop_q   <= blkop_d;
            aaddr_q   <= aaddr_d;
            rdata_q   <= rdata_d;
        end
    end

    assign array_req   = req_q;
    assign array_erase = erase_q;
    assign array_blk   = blkop_q;
    assign array_addr  = aaddr_q;

    // Checks on the sequencer and lock bits
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_refused_no_req: assert property (
        state_q == st_run && arr_cmd && prot |=> !array_req && refused_q)
        else $error("protected request was granted");
    a_granted_pulse: assert property (
        state_q == st_run && arr_cmd && !prot |=> array_req ##1 !array_req)
        else $error("granted request not a single pulse");
    a_lock_clears: assert property (
        state_q == st_run && cmd_q == CMD_LOCK && !hw_hold |=> !lock_q[$past(unit)])
        else $error("lock command left bit set");
    a_unlock_sets: assert property (
        state_q == st_run && cmd_q == CMD_UNLOCK && !hw_hold |=> lock_q[$past(unit)])
        else $error("unlock command left bit clear");
    a_global_lock: assert property (
        state_q == st_run && cmd_q == CMD_GLOCK && !hw_hold |=> lock_q == {UNIT_CNT{1'b0}})
        else $error("global lock incomplete");
    a_global_unlock: assert property (
        state_q == st_run && cmd_q == CMD_GUNLOCK && !hw_hold |=> lock_q == {UNIT_CNT{1'b1}})
        else $error("global unlock incomplete");
    a_read_bit: assert property (
        state_q == st_run && cmd_q == CMD_READ |=> rd_bit_q == $past(cur_bit))
        else $error("lock read returned wrong bit");
    a_reset_default: assert property (
        hw_hold |=> lock_q == $past(lock_dflt))
        else $error("hardware reset default not loaded");
    a_idle_stable: assert property (
        state_q == st_idle && !hw_hold |=> $stable(lock_q))
        else $error("lock bits changed without command");
    a_legacy_all: assert property (
        state_q == st_run && arr_cmd && !ctrl_q[CTRL_WPS] && ctrl_q[3:0] >= LVL_ALL
        |=> refused_q)
        else $error("full legacy level did not refuse");
    a_pointer_all: assert property (
        state_q == st_run && arr_cmd && ctrl_q[CTRL_PRG] && ctrl_q[CTRL_PALL] |=> refused_q)
        else $error("pointer all did not refuse");
    a_run_one_cycle: assert property (
        state_q == st_run |=> state_q == st_idle)
        else $error("sequencer stuck in run");

    c_prog_granted: cover property (state_q == st_run && cmd_q == CMD_PROG && !prot);
    c_erase_refused: cover property (state_q == st_run && cmd_q == CMD_ERASE_BLK && prot);
    c_global_unlock: cover property (state_q == st_run && cmd_q == CMD_GUNLOCK);
    c_read_open: cover property (state_q == st_run && cmd_q == CMD_READ && cur_bit);
endmodule
